// ==== bench/reset_source_control_tb_top.sv ====
// self-checking bench for the reset source controller
`timescale 1ns/100ps
`default_nettype none
module reset_source_control_tb_top;
  localparam int HOLD = 4;
  logic mclk;
  logic rst_n;
  logic pre_backup_select;
  rsc_pkg::rsc_axi_req_type req;
  rsc_pkg::rsc_axi_rsp_type rsp;
  wire logic pin_n, wdt, lv, osc, sup, rdy;
  logic sys_reset_n, cpu_run, emerg, sdi, stop_rel, irq;
  logic [31:0] fetch_addr, rd_v;
  logic [1:0] resp;
  int err_total, samples_checked, cyc, wake_cnt, n;
  int row_sel [4] = '{0, 2, 1, 0};
  logic [31:0] row_exp [4] = '{32'h0000_0010, 32'h0000_0012, 32'h0000_0013, 32'h0000_0013};
  rsc_source_model u_src (.mclk(mclk), .reset_pin_n(pin_n), .watchdog_reset_request(wdt),
    .supply_drop_reset(lv), .oscillation_stop_monitor(osc), .supply_level_ok(sup), .main_clock_ready(rdy));
  rsc_top #(.HOLD_CYCLES(16'h0004)) DUT (.mclk(mclk), .rst_n(rst_n), .reset_pin_n(pin_n),
    .watchdog_reset_request(wdt), .supply_drop_reset(lv), .oscillation_stop_monitor(osc),
    .supply_level_ok(sup), .main_clock_ready(rdy), .pre_backup_select(pre_backup_select),
    .s_axi_req(req), .s_axi_rsp(rsp), .sys_reset_n(sys_reset_n), .cpu_run(cpu_run),
    .fetch_addr(fetch_addr), .emergency_clock_select(emerg), .supply_drop_interrupt(sdi),
    .stop_release(stop_rel), .irq(irq));
  // ****************************************
  // helpers
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("counts: %0d mismatches in %0d compares", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge mclk)
  begin
    cyc++;
    if (sdi === 1'b1 && stop_rel === 1'b1)
      wake_cnt++;
    if (cyc == 20000)
    begin
      err_total++;
      $display("mismatch t=%0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic wait_lvl(ref logic s, input logic v);
    while (s !== v)
      @(posedge mclk);
  endtask : wait_lvl
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge mclk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= s;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    while (!(aw && w))
    begin
      @(posedge mclk);
      // each channel drops its valid right after the edge that took it
      aw = aw || rsp.awready === 1'b1;
      w = w || rsp.wready === 1'b1;
      req.awvalid <= !aw;
      req.wvalid <= !w;
    end
    do @(posedge mclk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do @(posedge mclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge mclk); while (rsp.rvalid !== 1'b1);
    rd_v = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rd
  task automatic event_reset(input int k);
    @(posedge mclk);
    u_src.pulse(k);
    wait_lvl(sys_reset_n, 1'b0);
    n = 0;
    while (sys_reset_n !== 1'b1)
    begin
      @(posedge mclk);
      n++;
    end
    chk_bit(n == HOLD, 1'b1);
  endtask : event_reset
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    req = '0;
    rst_n = 1'b0;
    pre_backup_select = 1'b0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_bit(sys_reset_n, 1'b0);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0000);
    u_src.pin(1'b1);
    wait_lvl(cpu_run, 1'b1);
    chk_reg(fetch_addr, 32'h0000_0000);
    chk_bit(sys_reset_n, 1'b1);
    $display("test power_up done");
    for (int i = 0; i < 4; i++)
    begin
      event_reset(row_sel[i]);
      wait_lvl(cpu_run, 1'b1);
      rd(rsc_pkg::FLAGS_ADDR);
      chk_reg(rd_v, row_exp[i]);
    end
    $display("test source_rows done");
    wr(rsc_pkg::FLAGS_ADDR, 32'h0000_0000);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0013);
    wr(rsc_pkg::PROTECT_ADDR, rsc_pkg::PROTECT_KEY);
    wr(rsc_pkg::FLAGS_ADDR, 32'h0000_00ef);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0003);
    wr(rsc_pkg::PROTECT_ADDR, rsc_pkg::PROTECT_KEY);
    wr(rsc_pkg::FLAGS_ADDR, 32'h0000_0000, 4'h0);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0003);
    wr(rsc_pkg::PROTECT_ADDR, rsc_pkg::PROTECT_KEY);
    wr(rsc_pkg::BIT_ADDR, 32'h0000_0001);
    wr(rsc_pkg::BIT_ADDR, 32'h0000_0000);
    rd(rsc_pkg::BIT_ADDR);
    chk_reg(rd_v, 32'h0000_0080);
    rd(32'hffff_f8a0);
    chk_reg({rd_v[29:0], resp}, 32'h0000_0003);
    $display("test protected_writes done");
    wr(rsc_pkg::IRQ_MASK_ADDR, 32'h0000_0002);
    @(posedge mclk);
    u_src.ready(1'b0);
    wr(rsc_pkg::PROTECT_ADDR, rsc_pkg::PROTECT_KEY);
    // clear of the watchdog flag lands in the cycle of its reset
    fork
      wr(rsc_pkg::FLAGS_ADDR, 32'h0000_00ef);
      event_reset(0);
    join
    // overflow in stabilisation: no reset, so no wait for one
    @(posedge mclk);
    u_src.pulse(0);
    wait_lvl(cpu_run, 1'b1);
    chk_bit(emerg, 1'b1);
    chk_bit(irq, 1'b1);
    rd(rsc_pkg::IRQ_STATUS_ADDR);
    chk_reg(rd_v, 32'h0000_0006);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0011);
    chk_bit(irq, 1'b0);
    $display("test emergency done");
    u_src.ready(1'b1);
    wake_cnt = 0;
    u_src.pulse(3);
    repeat (10) @(posedge mclk);
    chk_reg(wake_cnt, 32'h0000_0000);
    pre_backup_select <= 1'b1;
    u_src.pulse(3);
    repeat (10) @(posedge mclk);
    chk_reg(wake_cnt, 32'h0000_0001);
    u_src.pin(1'b0);
    repeat (5) @(posedge mclk);
    u_src.pin(1'b1);
    wait_lvl(cpu_run, 1'b1);
    rd(rsc_pkg::FLAGS_ADDR);
    chk_reg(rd_v, 32'h0000_0000);
    chk_bit(emerg, 1'b0);
    chk_bit(irq, 1'b0);
    $display("test pin_reset done");
    complete_run();
  end
endmodule : reset_source_control_tb_top
`default_nettype wire

// ==== bench/rsc_source_model.sv ====
// model of the reset sources: pin, watchdog and the two monitors
`timescale 1ns/100ps
`default_nettype none
module rsc_source_model (
  input wire logic mclk,
  output var logic reset_pin_n,
  output logic watchdog_reset_request,
  output logic supply_drop_reset,
  output logic oscillation_stop_monitor,
  output logic supply_level_ok,
  output var logic main_clock_ready
);
  logic [3:0] ev = 4'h0;
  logic [1:0] len = 2'h0;
  initial
  begin
    reset_pin_n = 1'b0;
    main_clock_ready = 1'b1;
  end
  // events held four cycles so the two-stage sync cannot miss them
  assign watchdog_reset_request = ev[0];
  assign supply_drop_reset = ev[1];
  assign oscillation_stop_monitor = ev[2];
  assign supply_level_ok = ev[3];
  always @(posedge mclk)
  begin
    if (ev != 4'h0)
    begin
      len <= len + 2'h1;
      if (len == 2'h3)
        ev <= 4'h0;
    end
  end
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
  endtask : pulse
  task automatic pin(input logic v);
    reset_pin_n <= v;
  endtask : pin
  task automatic ready(input logic v);
    main_clock_ready <= v;
  endtask : ready
endmodule : rsc_source_model
`default_nettype wire

// ==== logic/rsc_axil.sv ====
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/100ps
`default_nettype none
module rsc_axil (
  input wire logic mclk,
  input wire logic rst_n,
  input wire rsc_pkg::rsc_axi_req_type s_axi_req,
  output rsc_pkg::rsc_axi_rsp_type s_axi_rsp,
  output rsc_pkg::rsc_wr_type wr,
  input wire logic [1:0] wr_resp,
  output rsc_pkg::rsc_rd_type rd,
  input wire logic [31:0] rd_data,
  input wire logic [1:0] rd_resp
);
  typedef struct packed {
    rsc_pkg::rsc_axi_rsp_type rsp;
    logic aw_have;
    logic [31:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    rsc_pkg::rsc_wr_type wr;
    rsc_pkg::rsc_rd_type rd;
  } rsc_axil_state_type;
  rsc_axil_state_type r_reg;
  rsc_axil_state_type r_next;
  always_comb
  begin
    r_next = r_reg;
    r_next.wr.valid = 1'h0;
    r_next.rd.valid = 1'h0;
    if (s_axi_req.awvalid && r_reg.rsp.awready)
    begin
      r_next.aw_have = 1'h1;
      r_next.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && r_reg.rsp.wready)
    begin
      r_next.w_have = 1'h1;
      r_next.wdata = s_axi_req.wdata;
      r_next.wstrb = s_axi_req.wstrb;
    end
    if (r_reg.aw_have && r_reg.w_have)
    begin
      r_next.wr = '{1'h1, r_reg.awaddr, r_reg.wdata, r_reg.wstrb};
      r_next.aw_have = 1'h0;
      r_next.w_have = 1'h0;
    end
    if (r_reg.wr.valid)
    begin
      r_next.rsp.bvalid = 1'h1;
      r_next.rsp.bresp = wr_resp;
    end
    if (r_reg.rsp.bvalid && s_axi_req.bready)
    begin
      r_next.rsp.bvalid = 1'h0;
    end
    // no new address or data until the response is gone
    r_next.rsp.awready = !r_next.aw_have && !r_next.wr.valid && !r_next.rsp.bvalid;
    r_next.rsp.wready = !r_next.w_have && !r_next.wr.valid && !r_next.rsp.bvalid;
    if (s_axi_req.arvalid && r_reg.rsp.arready)
    begin
      r_next.rd = '{1'h1, s_axi_req.araddr};
    end
    if (r_reg.rd.valid)
    begin
      r_next.rsp.rvalid = 1'h1;
      r_next.rsp.rdata = rd_data;
      r_next.rsp.rresp = rd_resp;
    end
    if (r_reg.rsp.rvalid && s_axi_req.rready)
    begin
      r_next.rsp.rvalid = 1'h0;
    end
    r_next.rsp.arready = !r_next.rd.valid && !r_next.rsp.rvalid;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r_reg <= '0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
  assign s_axi_rsp = r_reg.rsp;
  assign wr = r_reg.wr;
  assign rd = r_reg.rd;
endmodule : rsc_axil
`default_nettype wire

// ==== logic/rsc_pkg.sv ====
// constants, types and behaviour notes for the reset source controller
// Notes on behaviour
// RL1: system reset comes from pin, watchdog overflow, supply drop or oscillation stop.
// RL2: after reset the processor starts fetching at address zero.
// RL3: watchdog overflow during clock stabilisation selects internal oscillator emergency operation.
// RL4: in emergency operation software uses only internal-oscillator peripherals, no external serial clocks.
// RL5: flag register writes take effect only inside the protected write sequence.
// RL6: flag register is reachable as a whole byte and as single bits.
// RL7: external pin reset clears every flag to zero.
// RL8: watchdog flag bit 4, oscillation flag bit 1, supply flag bit 0, rest zero.
// RL9: an internal reset sets only its own flag, others keep their values.
// RL10: software writes only zeros, and a zero clears the addressed flag.
// RL11: a flag set by a reset wins over a simultaneous software clear.
// RL12: in pre-backup, supply recovery raises the supply interrupt and releases stop mode.
// RL13: system stays in reset while the pin is low, ends when it rises.
// RL14: watchdog reset lasts a fixed time, then ends by itself.
// RL15: writing one to a flag bit leaves that flag unchanged.
package rsc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] FLAGS_ADDR = 32'hffff_f888;
  localparam logic [31:0] PROTECT_ADDR = 32'hffff_f88c;
  localparam logic [31:0] BIT_ADDR = 32'hffff_f890;
  localparam logic [31:0] IRQ_STATUS_ADDR = 32'hffff_f894;
  localparam logic [31:0] IRQ_MASK_ADDR = 32'hffff_f898;
  localparam logic [31:0] STATUS_ADDR = 32'hffff_f89c;
  localparam int SEL_N = 6;
  localparam int SEL_FLAGS = 0;
  localparam int SEL_PROTECT = 1;
  localparam int SEL_BIT = 2;
  localparam int SEL_IRQ_STATUS = 3;
  localparam int SEL_IRQ_MASK = 4;
  localparam int SEL_STATUS = 5;
  localparam logic [31:0] PROTECT_KEY = 32'h0000_00a5;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_0000;
  // ****************************************
  // fields
  // ****************************************
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] FLAG_MASK = 8'h13;
  localparam int WDT_FLAG_BIT = 4;
  localparam int OSC_FLAG_BIT = 1;
  localparam int LV_FLAG_BIT = 0;
  localparam int BIT_IDX_W = 3;
  localparam int BIT_VAL_POS = 7;
  localparam int IRQ_W = 3;
  localparam int IRQ_SUPPLY_RISE = 0;
  localparam int IRQ_EMERGENCY = 1;
  localparam int IRQ_CPU_START = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam int SYN_W = 6;
  localparam int SYN_PIN = 0;
  localparam int SYN_WDT = 1;
  localparam int SYN_LV = 2;
  localparam int SYN_OSC = 3;
  localparam int SYN_SUPPLY = 4;
  localparam int SYN_CLK_RDY = 5;
  localparam logic [SYN_W-1:0] SYN_RESET = 6'h00;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int HOLD_TIME_NS = 1000;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] HOLD_CYCLES_DEF = CNT_W'((HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_PIN = 4'h2,
    ST_HOLD = 4'h4,
    ST_STAB = 4'h8
  } rsc_seq_type;
  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } rsc_axi_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rsc_axi_rsp_type;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } rsc_wr_type;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } rsc_rd_type;
endpackage : rsc_pkg

// ==== logic/rsc_sync.sv ====
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
`default_nettype none
module rsc_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } rsc_sync_state_type;
  rsc_sync_state_type r_reg;
  rsc_sync_state_type r_next;
  // first stage feeds only the second
  always_comb
  begin
    r_next.s1 = async_in;
    r_next.s2 = r_reg.s1;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r_reg.s1 <= RESET_VAL;
      r_reg.s2 <= RESET_VAL;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
  assign sync_out = r_reg.s2;
endmodule : rsc_sync
`default_nettype wire

// ==== logic/rsc_top.sv ====
// reset source controller: sequencer, cause flags, interrupts and register file
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
module rsc_top #(
  parameter logic [rsc_pkg::CNT_W-1:0] HOLD_CYCLES = rsc_pkg::HOLD_CYCLES_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic watchdog_reset_request,
  input wire logic supply_drop_reset,
  input wire logic oscillation_stop_monitor,
  input wire logic supply_level_ok,
  input wire logic main_clock_ready,
  input wire logic pre_backup_select,
  input wire rsc_pkg::rsc_axi_req_type s_axi_req,
  output rsc_pkg::rsc_axi_rsp_type s_axi_rsp,
  output logic sys_reset_n,
  output logic cpu_run,
  output logic [31:0] fetch_addr,
  output logic emergency_clock_select,
  output logic supply_drop_interrupt,
  output logic stop_release,
  output logic irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rsc_pkg::rsc_seq_type st;
    logic [rsc_pkg::CNT_W-1:0] cnt;
    logic [rsc_pkg::SYN_W-1:0] prev;
    logic [7:0] flags;
    logic armed;
    logic [rsc_pkg::BIT_IDX_W-1:0] bit_idx;
    logic emergency;
    logic sys_reset_n;
    logic cpu_run;
    logic [31:0] fetch_addr;
    logic supply_irq;
    logic stop_release;
    logic [rsc_pkg::IRQ_W-1:0] irq_status;
    logic [rsc_pkg::IRQ_W-1:0] irq_mask;
    logic irq;
  } rsc_core_type;
  rsc_core_type r_reg;
  rsc_core_type r_next;
  logic [rsc_pkg::SYN_W-1:0] sync;
  rsc_pkg::rsc_wr_type wr;
  rsc_pkg::rsc_rd_type rd;
  logic [1:0] wr_resp;
  logic [31:0] rd_data;
  logic [1:0] rd_resp;
  logic [rsc_pkg::SEL_N-1:0] wsel;
  logic [rsc_pkg::SEL_N-1:0] rsel;
  logic pin_ok;
  logic ev_wdt;
  logic ev_lv;
  logic ev_osc;
  logic ev_sup;
  logic src_reset;
  // ****************************************
  // address decode
  // ****************************************
  function automatic logic [rsc_pkg::SEL_N-1:0] reg_sel(input logic [31:0] addr);
    logic [rsc_pkg::SEL_N-1:0] s;
    s = '0;
    s[rsc_pkg::SEL_FLAGS] = (addr == rsc_pkg::FLAGS_ADDR);
    s[rsc_pkg::SEL_PROTECT] = (addr == rsc_pkg::PROTECT_ADDR);
    s[rsc_pkg::SEL_BIT] = (addr == rsc_pkg::BIT_ADDR);
    s[rsc_pkg::SEL_IRQ_STATUS] = (addr == rsc_pkg::IRQ_STATUS_ADDR);
    s[rsc_pkg::SEL_IRQ_MASK] = (addr == rsc_pkg::IRQ_MASK_ADDR);
    s[rsc_pkg::SEL_STATUS] = (addr == rsc_pkg::STATUS_ADDR);
    return s;
  endfunction : reg_sel
  // ****************************************
  // inputs and bus
  // ****************************************
  rsc_sync #(
    .W(rsc_pkg::SYN_W),
    .RESET_VAL(rsc_pkg::SYN_RESET)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({main_clock_ready, supply_level_ok, oscillation_stop_monitor,
               supply_drop_reset, watchdog_reset_request, reset_pin_n}),
    .sync_out(sync)
  );
  rsc_axil u_axil (
    .mclk(mclk),
    .rst_n(rst_n),
    .s_axi_req(s_axi_req),
    .s_axi_rsp(s_axi_rsp),
    .wr(wr),
    .wr_resp(wr_resp),
    .rd(rd),
    .rd_data(rd_data),
    .rd_resp(rd_resp)
  );
  assign wsel = reg_sel(wr.addr);
  assign rsel = reg_sel(rd.addr);
  assign wr_resp = (|wsel) ? rsc_pkg::RESP_OKAY : rsc_pkg::RESP_DECERR;
  assign pin_ok = sync[rsc_pkg::SYN_PIN];
  // edges of the synchronised levels; the stored copy is one cycle old
  assign ev_wdt = sync[rsc_pkg::SYN_WDT] & ~r_reg.prev[rsc_pkg::SYN_WDT];
  assign ev_lv = sync[rsc_pkg::SYN_LV] & ~r_reg.prev[rsc_pkg::SYN_LV];
  assign ev_osc = sync[rsc_pkg::SYN_OSC] & ~r_reg.prev[rsc_pkg::SYN_OSC];
  assign ev_sup = sync[rsc_pkg::SYN_SUPPLY] & ~r_reg.prev[rsc_pkg::SYN_SUPPLY];
  // watchdog overflow in the stabilisation wait is not a reset
  assign src_reset = pin_ok && ((ev_wdt && r_reg.st != rsc_pkg::ST_STAB) || ev_lv || ev_osc); // RL1
  // ****************************************
  // read data
  // ****************************************
  always_comb
  begin
    rd_data = 32'h0000_0000;
    rd_resp = rsc_pkg::RESP_OKAY;
    case (1'h1)
      rsel[rsc_pkg::SEL_FLAGS]: rd_data = {24'h00_0000, r_reg.flags}; // RL6
      rsel[rsc_pkg::SEL_PROTECT]: rd_data = {31'h0000_0000, r_reg.armed};
      rsel[rsc_pkg::SEL_BIT]: rd_data = {24'h00_0000, r_reg.flags[r_reg.bit_idx], 4'h0, r_reg.bit_idx}; // RL6
      rsel[rsc_pkg::SEL_IRQ_STATUS]: rd_data = {29'h0000_0000, r_reg.irq_status};
      rsel[rsc_pkg::SEL_IRQ_MASK]: rd_data = {29'h0000_0000, r_reg.irq_mask};
      rsel[rsc_pkg::SEL_STATUS]: rd_data = {25'h000_0000, r_reg.emergency, r_reg.cpu_run, r_reg.sys_reset_n, r_reg.st};
      default: rd_resp = rsc_pkg::RESP_DECERR;
    endcase
  end
  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    r_next = r_reg;
    r_next.prev = sync;
    r_next.supply_irq = 1'h0;
    r_next.stop_release = 1'h0;
    // software side first, so hardware sets below win
    if (rd.valid && rsel[rsc_pkg::SEL_IRQ_STATUS])
    begin
      r_next.irq_status = rsc_pkg::IRQ_RESET;
    end
    if (wr.valid)
    begin
      // any write closes the protected window
      r_next.armed = 1'h0; // RL5
      if (wsel[rsc_pkg::SEL_PROTECT] && wr.strb[0])
      begin
        r_next.armed = (wr.data == rsc_pkg::PROTECT_KEY);
      end
      if (wsel[rsc_pkg::SEL_FLAGS] && wr.strb[0] && r_reg.armed) // RL5
      begin
        // zeros clear, ones keep
        r_next.flags = r_reg.flags & (wr.data[7:0] | ~rsc_pkg::FLAG_MASK) & rsc_pkg::FLAG_MASK; // RL10 RL15
      end
      if (wsel[rsc_pkg::SEL_BIT] && wr.strb[0])
      begin
        r_next.bit_idx = wr.data[rsc_pkg::BIT_IDX_W-1:0];
        if (r_reg.armed && !wr.data[rsc_pkg::BIT_VAL_POS]) // RL6 RL10
        begin
          r_next.flags[wr.data[rsc_pkg::BIT_IDX_W-1:0]] = 1'h0;
        end
      end
      if (wsel[rsc_pkg::SEL_IRQ_MASK] && wr.strb[0])
      begin
        r_next.irq_mask = wr.data[rsc_pkg::IRQ_W-1:0];
      end
    end
    case (r_reg.st)
      rsc_pkg::ST_PIN:
      begin
        if (pin_ok)
        begin
          r_next.st = rsc_pkg::ST_STAB; // RL13
        end
      end
      rsc_pkg::ST_HOLD:
      begin
        if (r_reg.cnt == '0)
        begin
          r_next.st = rsc_pkg::ST_STAB; // RL14
        end
        else
        begin
          r_next.cnt = r_reg.cnt - 1'h1;
        end
      end
      rsc_pkg::ST_STAB:
      begin
        if (ev_wdt)
        begin
          // main oscillator taken as faulty, run from the internal one
          r_next.emergency = 1'h1; // RL3
          r_next.irq_status[rsc_pkg::IRQ_EMERGENCY] = 1'h1;
          r_next.st = rsc_pkg::ST_RUN;
        end
        else if (sync[rsc_pkg::SYN_CLK_RDY])
        begin
          r_next.st = rsc_pkg::ST_RUN;
        end
      end
      rsc_pkg::ST_RUN:
      begin
        if (ev_sup && pre_backup_select)
        begin
          r_next.supply_irq = 1'h1; // RL12
          r_next.stop_release = 1'h1; // RL12
          r_next.irq_status[rsc_pkg::IRQ_SUPPLY_RISE] = 1'h1;
        end
      end
      default:
      begin
        r_next.st = rsc_pkg::ST_PIN;
      end
    endcase
    if (src_reset)
    begin
      r_next.st = rsc_pkg::ST_HOLD; // RL1 RL14
      r_next.cnt = HOLD_CYCLES - 1'h1;
      r_next.emergency = 1'h0;
      r_next.supply_irq = 1'h0;
      r_next.stop_release = 1'h0;
      // only the causing flag is set, after any clear above
      if (ev_wdt && r_reg.st != rsc_pkg::ST_STAB)
      begin
        r_next.flags[rsc_pkg::WDT_FLAG_BIT] = 1'h1; // RL9 RL11
      end
      if (ev_lv)
      begin
        r_next.flags[rsc_pkg::LV_FLAG_BIT] = 1'h1; // RL9 RL11
      end
      if (ev_osc)
      begin
        r_next.flags[rsc_pkg::OSC_FLAG_BIT] = 1'h1; // RL9 RL11
      end
    end
    if (!pin_ok)
    begin
      r_next.st = rsc_pkg::ST_PIN; // RL13
      r_next.flags = rsc_pkg::FLAGS_RESET; // RL7
      r_next.emergency = 1'h0;
      r_next.supply_irq = 1'h0;
      r_next.stop_release = 1'h0;
    end
    r_next.flags = r_next.flags & rsc_pkg::FLAG_MASK; // RL8
    r_next.sys_reset_n = (r_next.st != rsc_pkg::ST_PIN) && (r_next.st != rsc_pkg::ST_HOLD);
    r_next.cpu_run = (r_next.st == rsc_pkg::ST_RUN);
    if (r_next.cpu_run && !r_reg.cpu_run)
    begin
      r_next.irq_status[rsc_pkg::IRQ_CPU_START] = 1'h1;
    end
    // vector held at zero while not running, so the core always starts there
    if (!r_next.cpu_run)
    begin
      r_next.fetch_addr = rsc_pkg::RESET_VECTOR; // RL2
    end
    r_next.irq = |(r_next.irq_status & r_next.irq_mask);
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r_reg.st <= rsc_pkg::ST_PIN;
      r_reg.cnt <= '0;
      r_reg.prev <= rsc_pkg::SYN_RESET;
      r_reg.flags <= rsc_pkg::FLAGS_RESET;
      r_reg.armed <= 1'h0;
      r_reg.bit_idx <= '0;
      r_reg.emergency <= 1'h0;
      r_reg.sys_reset_n <= 1'h0;
      r_reg.cpu_run <= 1'h0;
      r_reg.fetch_addr <= rsc_pkg::RESET_VECTOR;
      r_reg.supply_irq <= 1'h0;
      r_reg.stop_release <= 1'h0;
      r_reg.irq_status <= rsc_pkg::IRQ_RESET;
      r_reg.irq_mask <= rsc_pkg::IRQ_RESET;
      r_reg.irq <= 1'h0;
    end
    else
    begin
      r_reg <= r_next;
    end
  end
  assign sys_reset_n = r_reg.sys_reset_n;
  assign cpu_run = r_reg.cpu_run;
  assign fetch_addr = r_reg.fetch_addr;
  assign emergency_clock_select = r_reg.emergency;
  assign supply_drop_interrupt = r_reg.supply_irq;
  assign stop_release = r_reg.stop_release;
  assign irq = r_reg.irq;
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  logic flag_wr;
  logic no_event;
  assign flag_wr = wr.valid && wsel[rsc_pkg::SEL_FLAGS] && wr.strb[0];
  assign no_event = pin_ok && !ev_wdt && !ev_lv && !ev_osc;
  sequence s_supply_rise;
    ev_sup && pre_backup_select && r_reg.st == rsc_pkg::ST_RUN && no_event;
  endsequence
  sequence s_wake_pulse;
    supply_drop_interrupt && stop_release ##1 !supply_drop_interrupt && !stop_release;
  endsequence
  a_source_resets: assert property (src_reset |=> !sys_reset_n && r_reg.cnt == HOLD_CYCLES - 1'h1) // RL1
    else $error("reset source did not start the hold");
  a_vector_start: assert property ($rose(cpu_run) |-> fetch_addr == rsc_pkg::RESET_VECTOR && $past(fetch_addr) == rsc_pkg::RESET_VECTOR) // RL2
    else $error("processor started away from the reset vector");
  a_emergency_entry: assert property (r_reg.st == rsc_pkg::ST_STAB && ev_wdt && pin_ok |=> emergency_clock_select && cpu_run) // RL3
    else $error("watchdog in stabilisation did not select emergency clock");
  a_unarmed_write: assert property (flag_wr && !r_reg.armed && no_event |=> $stable(r_reg.flags)) // RL5
    else $error("unprotected write changed the flags");
  a_pin_clears: assert property (!pin_ok |=> r_reg.flags == rsc_pkg::FLAGS_RESET && !emergency_clock_select) // RL7
    else $error("pin reset left flags set");
  a_reserved_zero: assert property ((r_reg.flags & ~rsc_pkg::FLAG_MASK) == 8'h00) // RL8
    else $error("reserved flag bit set");
  a_own_flag: assert property (ev_lv && pin_ok && !ev_wdt && !ev_osc && !wr.valid |=> r_reg.flags[rsc_pkg::LV_FLAG_BIT]
      && $stable(r_reg.flags[rsc_pkg::WDT_FLAG_BIT]) && $stable(r_reg.flags[rsc_pkg::OSC_FLAG_BIT])) // RL9
    else $error("supply reset disturbed another flag");
  a_zero_clears: assert property (flag_wr && r_reg.armed && !wr.data[rsc_pkg::LV_FLAG_BIT] && no_event
      |=> !r_reg.flags[rsc_pkg::LV_FLAG_BIT]) // RL10
    else $error("written zero did not clear the flag");
  a_set_wins: assert property (flag_wr && r_reg.armed && ev_wdt && pin_ok && r_reg.st != rsc_pkg::ST_STAB
      |=> r_reg.flags[rsc_pkg::WDT_FLAG_BIT]) // RL11
    else $error("software clear beat the reset flag");
  a_supply_wake: assert property (s_supply_rise |=> s_wake_pulse) // RL12
    else $error("supply recovery did not wake the device");
  a_pin_holds: assert property (!pin_ok ##1 !pin_ok |-> !sys_reset_n && r_reg.st == rsc_pkg::ST_PIN) // RL13
    else $error("system left reset while the pin was low");
  a_hold_end: assert property (r_reg.st == rsc_pkg::ST_HOLD && r_reg.cnt == '0 && no_event |=> sys_reset_n && r_reg.st == rsc_pkg::ST_STAB) // RL14
    else $error("watchdog reset hold did not end");
  a_write_one_keeps: assert property (flag_wr && r_reg.armed && wr.data[rsc_pkg::WDT_FLAG_BIT]
      && r_reg.flags[rsc_pkg::WDT_FLAG_BIT] && pin_ok |=> r_reg.flags[rsc_pkg::WDT_FLAG_BIT]) // RL15
    else $error("written one cleared the flag");
endmodule : rsc_top
`default_nettype wire
